// file: verilog/acp_config_port.sv
`timescale 1ns/1ns

module acp_config_port
    import acp_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       serial_clk_in,
    input  wire logic       serial_enable_n_in,
    input  wire logic       serial_data_pin_in,
    input  wire logic       reset_pin_in,
    input  wire logic       powerdown_pin_in,
    input  wire logic [1:0] gain_ref_level_in,
    input  wire logic [1:0] interface_width_strap_in,
    input  wire logic [1:0] serialization_strap_in,
    input  wire logic [1:0] bit_order_format_strap_in,
    input  wire logic       chan_a_powerdown_pin_in,
    input  wire logic       chan_b_powerdown_pin_in,
    output logic            two_wire_out,
    output logic            sdr_clock_out,
    output logic            ser_14x_out,
    output logic            capture_rising_out,
    output logic            lsb_first_out,
    output logic            offset_binary_out,
    output logic            coarse_gain_out,
    output logic            internal_ref_out,
    output logic            global_pdn_out,
    output logic            chan_a_pdn_out,
    output logic            chan_b_pdn_out,
    output logic [2:0]      pattern_sel_out
);

    localparam int EFF_CYC = EFFECT_MAX_CYC;
    localparam int SYNC_W  = 15;

    // ---------------- serial clock domain ----------------
    logic [CNT_BITS-1:0]  bit_cnt_reg;
    logic [CNT_BITS-1:0]  bit_cnt_next;
    logic [WORD_BITS-2:0] shift_reg;
    logic [WORD_BITS-1:0] word_hold_reg;
    logic                 commit_tog_reg;
    wire                  commit_hit;

    assign bit_cnt_next = bit_cnt_reg + 4'h1;
    assign commit_hit   = !serial_enable_n_in && (bit_cnt_reg == CNT_LAST);

    // enable high clears the count at once, dropping any partial word
    always_ff @(negedge serial_clk_in or posedge serial_enable_n_in)
    begin
        if (serial_enable_n_in)
            bit_cnt_reg <= '0;
        else
            bit_cnt_reg <= bit_cnt_next;
    end

    always_ff @(negedge serial_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            shift_reg <= '0;
        else if (!serial_enable_n_in)
            shift_reg <= {shift_reg[WORD_BITS-3:0], serial_data_pin_in};
    end

    // word stays put for 16 serial clocks, far longer than the crossing
    always_ff @(negedge serial_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            word_hold_reg  <= '0;
            commit_tog_reg <= 1'b0;
        end
        else if (commit_hit)
        begin
            word_hold_reg  <= {shift_reg, serial_data_pin_in};
            commit_tog_reg <= ~commit_tog_reg;
        end
    end

    // ---------------- system clock domain ----------------
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              tog_d_reg;
    wire  [SYNC_W-1:0] pins_raw;

    assign pins_raw = {commit_tog_reg, reset_pin_in, powerdown_pin_in,
                       chan_a_powerdown_pin_in, chan_b_powerdown_pin_in,
                       serial_clk_in, serial_data_pin_in, gain_ref_level_in,
                       interface_width_strap_in, serialization_strap_in,
                       bit_order_format_strap_in};

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tog_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            tog_d_reg <= sync2_reg[14];
        end
    end

    wire       tog_s       = sync2_reg[14];
    wire       pin_mode    = sync2_reg[13];
    wire       pdn_pin_s   = sync2_reg[12];
    wire       cha_pin_s   = sync2_reg[11];
    wire       chb_pin_s   = sync2_reg[10];
    wire       sclk_s      = sync2_reg[9];
    wire       serial_data_pin_s     = sync2_reg[8];
    wire [1:0] gain_lvl_s  = sync2_reg[7:6];
    wire [1:0] width_lvl_s = sync2_reg[5:4];
    wire [1:0] ser_lvl_s   = sync2_reg[3:2];
    wire [1:0] order_lvl_s = sync2_reg[1:0];

    wire                  commit_pulse = tog_s ^ tog_d_reg;
    wire [ADDR_BITS-1:0]  wr_addr = word_hold_reg[WORD_BITS-1:DATA_BITS];
    wire [DATA_BITS-1:0]  wr_data = word_hold_reg[DATA_BITS-1:0];

    // register reset: pin asserts at once, release is synchronised
    logic rrst_s1_reg;
    logic rrst_n_reg;
    wire  reg_arst_n = rst_b_in & ~reset_pin_in;

    always_ff @(posedge sys_clk_in or negedge reg_arst_n)
    begin
        if (!reg_arst_n)
        begin
            rrst_s1_reg <= 1'b0;
            rrst_n_reg  <= 1'b0;
        end
        else
        begin
            rrst_s1_reg <= 1'b1;
            rrst_n_reg  <= rrst_s1_reg;
        end
    end

    logic [DATA_BITS-1:0] main_ctrl_reg;
    logic [DATA_BITS-1:0] main_ctrl_next;
    logic [DATA_BITS-1:0] test_pat_reg;
    logic [DATA_BITS-1:0] test_pat_next;
    logic [DATA_BITS-1:0] out_iface_reg;
    logic [DATA_BITS-1:0] out_iface_next;

    wire soft_reset = commit_pulse && (wr_addr == ADDR_MAIN_CONTROL) &&
                      wr_data[MC_SOFT_RESET];
    wire wr_main = commit_pulse && (wr_addr == ADDR_MAIN_CONTROL);
    wire wr_tpat = commit_pulse && (wr_addr == ADDR_TEST_PATTERN_SELECT);
    wire wr_oifc = commit_pulse && (wr_addr == ADDR_OUTPUT_IFACE_CTRL);

    // reset bit is never stored, so it always reads back as cleared
    assign main_ctrl_next = soft_reset ? MAIN_CONTROL_RESET :
                            wr_main ? (wr_data & ~(11'h001 << MC_SOFT_RESET)) :
                            main_ctrl_reg;
    assign test_pat_next  = soft_reset ? TEST_PATTERN_RESET :
                            wr_tpat ? wr_data : test_pat_reg;
    assign out_iface_next = soft_reset ? OUTPUT_IFACE_RESET :
                            wr_oifc ? wr_data : out_iface_reg;

    always_ff @(posedge sys_clk_in or negedge rrst_n_reg)
    begin
        if (!rrst_n_reg)
        begin
            main_ctrl_reg <= MAIN_CONTROL_RESET;
            test_pat_reg  <= TEST_PATTERN_RESET;
            out_iface_reg <= OUTPUT_IFACE_RESET;
        end
        else
        begin
            main_ctrl_reg <= main_ctrl_next;
            test_pat_reg  <= test_pat_next;
            out_iface_reg <= out_iface_next;
        end
    end

    // ---------------- mode resolution ----------------
    wire ovrd = out_iface_reg[OI_OVERRIDE];

    // strap decode; the unused width level falls back to 1-wire DDR
    wire strap_two_wire = (width_lvl_s == LVL_5_8) ||
                          (width_lvl_s == LVL_SUPPLY);
    wire strap_sdr      = (width_lvl_s == LVL_5_8);
    wire strap_ser14    = (ser_lvl_s == LVL_3_8) || (ser_lvl_s == LVL_5_8);
    wire strap_rising   = (ser_lvl_s == LVL_5_8) || (ser_lvl_s == LVL_SUPPLY);
    wire strap_lsb      = (order_lvl_s == LVL_5_8) ||
                          (order_lvl_s == LVL_SUPPLY);
    wire strap_offbin   = (order_lvl_s == LVL_3_8) ||
                          (order_lvl_s == LVL_5_8);

    wire pin_gain   = (gain_lvl_s == LVL_3_8) || (gain_lvl_s == LVL_5_8);
    wire pin_intref = (gain_lvl_s == LVL_5_8) || (gain_lvl_s == LVL_SUPPLY);

    wire [2:0] pin_pattern = (!sclk_s && serial_data_pin_s) ? PAT_SYNC :
                             (sclk_s && serial_data_pin_s) ? PAT_DESKEW :
                             PAT_NORMAL;
    wire       pin_gpdn    = sclk_s && !serial_data_pin_s;

    wire ovr_sel = ovrd && !pin_mode;
    wire two_wire_next  = ovr_sel ? out_iface_reg[OI_TWO_WIRE] : strap_two_wire;
    wire sdr_next       = ovr_sel ? out_iface_reg[OI_SDR] : strap_sdr;
    wire ser14_next     = ovr_sel ? out_iface_reg[OI_SER_14X] : strap_ser14;
    wire rising_next    = ovr_sel ? out_iface_reg[OI_CAPTURE_RISING] : strap_rising;
    wire lsb_next       = ovr_sel ? out_iface_reg[OI_LSB_FIRST] : strap_lsb;
    wire offbin_next    = ovr_sel ? test_pat_reg[TP_OFFSET_BIN] : strap_offbin;
    wire gain_next      = pin_mode ? pin_gain :
                          (ovrd && out_iface_reg[OI_COARSE_GAIN]);
    wire intref_next    = pin_mode ? pin_intref : main_ctrl_reg[MC_REF_INTERNAL];
    wire [2:0] pat_next = pin_mode ? pin_pattern :
                          test_pat_reg[TP_PAT_HI:TP_PAT_LO];
    wire gpdn_next      = pdn_pin_s ||
                          (pin_mode ? pin_gpdn : main_ctrl_reg[MC_PDN_GLOBAL]);
    wire cha_next       = cha_pin_s || (!pin_mode && main_ctrl_reg[MC_PDN_CHA]);
    wire chb_next       = chb_pin_s || (!pin_mode && main_ctrl_reg[MC_PDN_CHB]);

    // strap-decoded outputs track the straps continuously unless ovr_sel hands them to the registers, so no reset is needed to apply them
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            two_wire_out       <= 1'b0;
            sdr_clock_out      <= 1'b0;
            ser_14x_out        <= 1'b0;
            capture_rising_out <= 1'b0;
            lsb_first_out      <= 1'b0;
            offset_binary_out  <= 1'b0;
            coarse_gain_out    <= 1'b0;
            internal_ref_out   <= 1'b0;
            global_pdn_out     <= 1'b0;
            chan_a_pdn_out     <= 1'b0;
            chan_b_pdn_out     <= 1'b0;
            pattern_sel_out    <= PAT_NORMAL;
        end
        else
        begin
            two_wire_out       <= two_wire_next;
            sdr_clock_out      <= sdr_next;
            ser_14x_out        <= ser14_next;
            capture_rising_out <= rising_next;
            lsb_first_out      <= lsb_next;
            offset_binary_out  <= offbin_next;
            coarse_gain_out    <= gain_next;
            internal_ref_out   <= intref_next;
            global_pdn_out     <= gpdn_next;
            chan_a_pdn_out     <= cha_next;
            chan_b_pdn_out     <= chb_next;
            pattern_sel_out    <= pat_next;
        end
    end

    // ---------------- assertions ----------------
    AST_SHIFT_IDLE: assert property (
        @(negedge serial_clk_in) disable iff (!rst_b_in)
        serial_enable_n_in |-> (bit_cnt_reg == '0))
        else $error("bit count moved while enable high");

    AST_SAMPLE_FALL: assert property (
        @(negedge serial_clk_in) disable iff (!rst_b_in)
        !serial_enable_n_in |=> (shift_reg[0] == $past(serial_data_pin_in)))
        else $error("serial data not sampled on falling edge");

    AST_COMMIT_16: assert property (
        @(negedge serial_clk_in) disable iff (!rst_b_in)
        (!serial_enable_n_in && bit_cnt_reg == CNT_LAST)
        |=> (commit_tog_reg != $past(commit_tog_reg)))
        else $error("no commit on 16th edge");

    AST_NO_PARTIAL: assert property (
        @(negedge serial_clk_in) disable iff (!rst_b_in)
        (bit_cnt_reg != CNT_LAST) |=> $stable(commit_tog_reg))
        else $error("commit on partial word");

    AST_SOFT_RESET: assert property (
        @(posedge sys_clk_in) disable iff (!rrst_n_reg)
        soft_reset |=> (main_ctrl_reg == MAIN_CONTROL_RESET &&
                        test_pat_reg == TEST_PATTERN_RESET &&
                        out_iface_reg == OUTPUT_IFACE_RESET))
        else $error("soft reset did not restore defaults");

    AST_STRAP_WIDTH: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!ovrd && width_lvl_s == LVL_GND) |=> !two_wire_out)
        else $error("width strap ignored with override low");

    AST_PDN_PIN: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        pdn_pin_s |=> global_pdn_out)
        else $error("power-down pin did not force power-down");

    AST_GAIN_DEFAULT: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!pin_mode && !ovrd) |=> !coarse_gain_out)
        else $error("coarse gain set with override low");

    AST_DESKEW_PIN: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (pin_mode && sclk_s && serial_data_pin_s) |=> (pattern_sel_out == PAT_DESKEW))
        else $error("deskew pattern not selected by pins");

    AST_CHAN_PDN: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        cha_pin_s && chb_pin_s |=> (chan_a_pdn_out && chan_b_pdn_out))
        else $error("channel power-down pin ignored");

    AST_EFFECT_TIME: assert property (
        @(posedge sys_clk_in) disable iff (!rrst_n_reg)
        (wr_tpat && !pin_mode) ##1 !pin_mode
        |-> ##[1:EFF_CYC] (pattern_sel_out == wr_data[TP_PAT_HI:TP_PAT_LO]))
        else $error("pattern write late");

    AST_OVR_WIDTH: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        ovr_sel |=> (two_wire_out == $past(out_iface_reg[OI_TWO_WIRE])))
        else $error("override did not hand width to register");

    AST_STRAP_SDR: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!ovr_sel && width_lvl_s == LVL_5_8) |=> (two_wire_out && sdr_clock_out))
        else $error("width strap did not select two-wire single rate");

    AST_STRAP_SER: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!ovr_sel && ser_lvl_s == LVL_3_8) |=> (ser_14x_out && !capture_rising_out))
        else $error("serialization strap decoded wrongly");

    AST_STRAP_ORDER: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!ovr_sel && order_lvl_s == LVL_SUPPLY) |=> (lsb_first_out && !offset_binary_out))
        else $error("bit order strap decoded wrongly");

    AST_PIN_GAIN: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (pin_mode && gain_lvl_s == LVL_5_8) |=> (coarse_gain_out && internal_ref_out))
        else $error("enable level did not pick internal reference with gain");

    AST_PIN_SYNC: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (pin_mode && !sclk_s && serial_data_pin_s) |=> (pattern_sel_out == PAT_SYNC))
        else $error("sync pattern not selected by pins");

    AST_REF_REG: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        !pin_mode |=> (internal_ref_out == $past(main_ctrl_reg[MC_REF_INTERNAL])))
        else $error("reference does not follow register bit");

endmodule : acp_config_port

// file: verilog/acp_pkg.sv
package acp_pkg;

    // serial word layout
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 11;
    localparam int CNT_BITS  = 4;
    localparam logic [CNT_BITS-1:0] CNT_LAST = 4'hf;

    // register addresses
    localparam logic [ADDR_BITS-1:0] ADDR_MAIN_CONTROL       = 5'h00;
    localparam logic [ADDR_BITS-1:0] ADDR_TEST_PATTERN_SELECT = 5'h0a;
    localparam logic [ADDR_BITS-1:0] ADDR_OUTPUT_IFACE_CTRL  = 5'h0d;

    // main_control fields
    localparam int MC_SOFT_RESET   = 10;
    localparam int MC_REF_INTERNAL = 6;
    localparam int MC_PDN_CHB      = 3;
    localparam int MC_PDN_CHA      = 2;
    localparam int MC_PDN_GLOBAL   = 0;

    // test_pattern_select fields
    localparam int TP_OFFSET_BIN = 9;
    localparam int TP_PAT_HI     = 7;
    localparam int TP_PAT_LO     = 5;

    // output_interface_control fields
    localparam int OI_OVERRIDE       = 10;
    localparam int OI_LSB_FIRST      = 6;
    localparam int OI_COARSE_GAIN    = 5;
    localparam int OI_CAPTURE_RISING = 4;
    localparam int OI_SER_14X        = 2;
    localparam int OI_SDR            = 1;
    localparam int OI_TWO_WIRE       = 0;

    // values after reset
    localparam logic [DATA_BITS-1:0] MAIN_CONTROL_RESET = 11'h000;
    localparam logic [DATA_BITS-1:0] TEST_PATTERN_RESET = 11'h000;
    localparam logic [DATA_BITS-1:0] OUTPUT_IFACE_RESET = 11'h000;

    // four-level strap codes, lowest to highest
    localparam logic [1:0] LVL_GND    = 2'h0;
    localparam logic [1:0] LVL_3_8    = 2'h1;
    localparam logic [1:0] LVL_5_8    = 2'h2;
    localparam logic [1:0] LVL_SUPPLY = 2'h3;

    // output pattern codes
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_SYNC   = 3'h1;
    localparam logic [2:0] PAT_DESKEW = 3'h2;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int EFFECT_MAX_NS = 100;
    localparam int EFFECT_MAX_CYC = EFFECT_MAX_NS / CLK_PERIOD_NS;

endpackage : acp_pkg

// file: verification/acp_host_model.sv
`timescale 1ns/1ns

// host side of the configuration link; serial clock parks high between frames
module acp_host_model
(
    output logic serial_clk_out,
    output logic serial_enable_n_out,
    output logic serial_data_out
);
    localparam int HALF_NS = 80;
    int   frame_bits;
    event word_edge;

    initial
    begin
        serial_clk_out      = 1'b1;
        serial_enable_n_out = 1'b0;
        serial_data_out     = 1'b0;
        frame_bits          = 0;
        // idle level arrives as a rising edge, which clears the bit count
        #1;
        serial_enable_n_out = 1'b1;
    end

    task begin_frame;
        serial_enable_n_out = 1'b0;
        frame_bits          = 0;
        #40;
    endtask : begin_frame

    // msb first; data moves only while the clock is high
    task shift_word(input logic [15:0] w, input int nb);
        for (int i = 0; i < nb; i++)
        begin
            serial_data_out = w[15-i];
            #HALF_NS;
            serial_clk_out = 1'b0;
            frame_bits++;
            if (frame_bits % 16 == 0)
                -> word_edge;
            #HALF_NS;
            serial_clk_out = 1'b1;
        end
    endtask : shift_word

    // released data line shows the inverse of its last value
    task end_frame;
        #40;
        serial_enable_n_out = 1'b1;
        serial_data_out     = ~serial_data_out;
    endtask : end_frame

    task idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            serial_data_out = ~serial_data_out;
            #HALF_NS;
            serial_clk_out = 1'b0;
            #HALF_NS;
            serial_clk_out = 1'b1;
        end
    endtask : idle_clocks

    task set_levels(input logic c, input logic d);
        // move off the system clock edge
        #1;
        serial_clk_out  = c;
        serial_data_out = d;
    endtask : set_levels
endmodule : acp_host_model

// file: verification/tb.sv
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); n_mismatch++; end end

module tb
    import acp_pkg::*;
;
    logic        sys_clk, rst_b, reset_pin, pdn_pin, pa, pb;
    logic [1:0]  gain_lvl, width_lvl, ser_lvl, order_lvl;
    logic        s_clk, s_en_n, s_dat;
    logic        two_w, sdr, s14, rise, lsb, ob, gain, iref, gpdn, apdn, bpdn;
    logic [2:0]  pat;
    logic [13:0] out_vec;
    int          n_mismatch, compares;

    assign out_vec = {two_w, sdr, s14, rise, lsb, ob, gain, iref, gpdn, apdn, bpdn, pat};

    acp_host_model host (.serial_clk_out(s_clk), .serial_enable_n_out(s_en_n),
                         .serial_data_out(s_dat));

    acp_config_port DUT (
        .sys_clk_in(sys_clk), .rst_b_in(rst_b), .serial_clk_in(s_clk),
        .serial_enable_n_in(s_en_n), .serial_data_pin_in(s_dat), .reset_pin_in(reset_pin),
        .powerdown_pin_in(pdn_pin), .gain_ref_level_in(gain_lvl),
        .interface_width_strap_in(width_lvl), .serialization_strap_in(ser_lvl),
        .bit_order_format_strap_in(order_lvl), .chan_a_powerdown_pin_in(pa),
        .chan_b_powerdown_pin_in(pb), .two_wire_out(two_w), .sdr_clock_out(sdr),
        .ser_14x_out(s14), .capture_rising_out(rise), .lsb_first_out(lsb),
        .offset_binary_out(ob), .coarse_gain_out(gain), .internal_ref_out(iref),
        .global_pdn_out(gpdn), .chan_a_pdn_out(apdn), .chan_b_pdn_out(bpdn),
        .pattern_sel_out(pat));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : settle

    task set_straps(input logic [1:0] lvl, input logic a, input logic b);
        @(posedge sys_clk);
        width_lvl <= lvl;
        ser_lvl   <= lvl;
        order_lvl <= lvl;
        pa        <= a;
        pb        <= b;
        settle(5);
    endtask : set_straps

    task write_reg(input logic [4:0] a, input logic [10:0] d);
        host.begin_frame();
        host.shift_word({a, d}, 16);
        host.end_frame();
        settle(2);
    endtask : write_reg

    task t_strap_decode;
        logic [13:0] e;
        for (int i = 0; i < 4; i++)
        begin
            set_straps(i[1:0], i[0], i[1]);
            e = {i >= 2, i == 2, i == 1 || i == 2, i >= 2, i >= 2, i == 1 || i == 2,
                 3'h0, i[0], i[1], 3'h0};
            `CHK("strap outputs", e, out_vec)
        end
        set_straps(2'h0, 1'b0, 1'b0);
    endtask : t_strap_decode

    task t_override_write;
        fork
            write_reg(ADDR_OUTPUT_IFACE_CTRL, 11'h477);
            begin
                @(host.word_edge);
                #(EFFECT_MAX_NS - 1);
                `CHK("override write", 14'h3e80, out_vec)
            end
        join
    endtask : t_override_write

    task t_multi_word;
        set_straps(2'h3, 1'b0, 1'b0);
        host.begin_frame();
        host.shift_word({ADDR_OUTPUT_IFACE_CTRL, 11'h400}, 16);
        host.shift_word({ADDR_TEST_PATTERN_SELECT, 11'h2a0}, 16);
        host.shift_word({ADDR_OUTPUT_IFACE_CTRL, 11'h7ff}, 12);
        host.end_frame();
        settle(12);
        `CHK("multi word", 14'h0105, out_vec)
        write_reg(5'h1d, 11'h7ff);
        `CHK("unmapped write", 14'h0105, out_vec)
        host.idle_clocks(16);
        settle(12);
        `CHK("clock while disabled", 14'h0105, out_vec)
    endtask : t_multi_word

    task t_main_control;
        set_straps(2'h0, 1'b0, 1'b0);
        write_reg(ADDR_MAIN_CONTROL, 11'h045);
        `CHK("main control", 14'h0175, out_vec)
        write_reg(ADDR_MAIN_CONTROL, 11'h040);
        `CHK("pdn bit clear", 14'h0145, out_vec)
        pdn_pin <= 1'b1;
        settle(5);
        `CHK("pdn pin forces", 14'h0165, out_vec)
        pdn_pin <= 1'b0;
        settle(5);
    endtask : t_main_control

    task t_soft_reset;
        write_reg(ADDR_MAIN_CONTROL, 11'h440);
        `CHK("soft reset", 14'h0000, out_vec)
        write_reg(ADDR_OUTPUT_IFACE_CTRL, 11'h421);
        `CHK("after soft reset", 14'h2080, out_vec)
        reset_pin <= 1'b1;
        settle(2);
        reset_pin <= 1'b0;
        settle(5);
        `CHK("reset pin pulse", 14'h0000, out_vec)
    endtask : t_soft_reset

    task t_pin_mode;
        logic [1:0] gr;
        reset_pin <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            host.set_levels(i[1], i[0]);
            settle(6);
            `CHK("pin pdn", i == 2, gpdn)
            if (i != 2)
                `CHK("pin pattern", (i == 1) ? PAT_SYNC : (i == 3) ? PAT_DESKEW : PAT_NORMAL, pat)
            gain_lvl <= i[1:0];
            settle(6);
            gr = {i == 1 || i == 2, i >= 2};
            `CHK("gain ref", gr, out_vec[7:6])
        end
        host.set_levels(1'b1, 1'b0);
        reset_pin <= 1'b0;
        settle(5);
    endtask : t_pin_mode

    initial
    begin
        n_mismatch = 0;
        compares   = 0;
        rst_b      = 1'b0;
        reset_pin  = 1'b0;
        pdn_pin    = 1'b0;
        pa         = 1'b0;
        pb         = 1'b0;
        gain_lvl   = 2'h0;
        width_lvl  = 2'h0;
        ser_lvl    = 2'h0;
        order_lvl  = 2'h0;
        settle(3);
        rst_b <= 1'b1;
        settle(3);
        reset_pin <= 1'b1;
        settle(2);
        reset_pin <= 1'b0;
        settle(5);
        `CHK("reset values", 14'h0000, out_vec)
        t_strap_decode();
        t_override_write();
        t_multi_word();
        t_main_control();
        t_soft_reset();
        t_pin_mode();
        report_and_stop();
    end

    // about 27 us of traffic expected; generous margin
    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb
